// >>> hdl/tstc_pkg.sv
// Constants and types for the temperature-sense trim and excitation block.
// Assumes a 32-bit APB bus and word-aligned register slots.
package tstc_pkg;

    // Bus widths
    localparam int unsigned TSTC_ADDR_W = 32;
    localparam int unsigned TSTC_DATA_W = 32;
    localparam int unsigned TSTC_REG_W = 8;
    localparam int unsigned TSTC_NREG = 6;

    // Register indices as printed; byte address is four times the index
    localparam logic [15:0] TSTC_IDX_T1_TRIM_UPPER = 16'hfe7c;
    localparam logic [15:0] TSTC_IDX_T1_TRIM_LOWER = 16'hfe7d;
    localparam logic [15:0] TSTC_IDX_T2_TRIM_UPPER = 16'hfe7e;
    localparam logic [15:0] TSTC_IDX_T2_TRIM_LOWER = 16'hfe7f;
    localparam logic [15:0] TSTC_IDX_T1_EXC = 16'hfe80;
    localparam logic [15:0] TSTC_IDX_T2_EXC = 16'hfe81;

    localparam logic [31:0] TSTC_ADDR_T1_TRIM_UPPER =
        {14'h0000, TSTC_IDX_T1_TRIM_UPPER, 2'b00};
    localparam logic [31:0] TSTC_ADDR_T1_TRIM_LOWER =
        {14'h0000, TSTC_IDX_T1_TRIM_LOWER, 2'b00};
    localparam logic [31:0] TSTC_ADDR_T2_TRIM_UPPER =
        {14'h0000, TSTC_IDX_T2_TRIM_UPPER, 2'b00};
    localparam logic [31:0] TSTC_ADDR_T2_TRIM_LOWER =
        {14'h0000, TSTC_IDX_T2_TRIM_LOWER, 2'b00};
    localparam logic [31:0] TSTC_ADDR_T1_EXC = {14'h0000, TSTC_IDX_T1_EXC, 2'b00};
    localparam logic [31:0] TSTC_ADDR_T2_EXC = {14'h0000, TSTC_IDX_T2_EXC, 2'b00};

    // Slot numbers inside the register array
    localparam int unsigned TSTC_SLOT_T1_UPPER = 0;
    localparam int unsigned TSTC_SLOT_T1_LOWER = 1;
    localparam int unsigned TSTC_SLOT_T2_UPPER = 2;
    localparam int unsigned TSTC_SLOT_T2_LOWER = 3;
    localparam int unsigned TSTC_SLOT_T1_EXC = 4;
    localparam int unsigned TSTC_SLOT_T2_EXC = 5;

    // Field positions
    localparam int unsigned TSTC_TRIM_MSB_BIT = 0;
    localparam int unsigned TSTC_TRIM_SIGN_BIT = 1;
    localparam int unsigned TSTC_COARSE_HI = 7;
    localparam int unsigned TSTC_COARSE_LO = 6;
    localparam int unsigned TSTC_FINE_HI = 5;
    localparam int unsigned TSTC_FINE_LO = 0;

    // Reset values: zero trim, 10 uA coarse, zero fine
    localparam logic [7:0] TSTC_RST_TRIM = 8'h00;
    localparam logic [7:0] TSTC_RST_EXC = 8'h00;

    // Converter reading and trim widths
    localparam int unsigned TSTC_ADC_W = 12;
    localparam int unsigned TSTC_MAG_W = 9;
    localparam int unsigned TSTC_CODE_W = 9;
    localparam logic [TSTC_ADC_W-1:0] TSTC_ADC_MAX = 12'hfff;
    localparam logic [TSTC_ADC_W-1:0] TSTC_ADC_MIN = 12'h000;

    // Excitation steps: coarse 10 uA, fine 156.25 nA
    localparam int unsigned TSTC_COARSE_STEP_PA = 10000000;
    localparam int unsigned TSTC_FINE_STEP_PA = 156250;
    localparam logic [TSTC_CODE_W-1:0] TSTC_FINE_PER_COARSE =
        TSTC_CODE_W'(TSTC_COARSE_STEP_PA / TSTC_FINE_STEP_PA);

    typedef enum logic {
        TSTC_SIGN_POS = 1'b0,
        TSTC_SIGN_NEG = 1'b1
    } tstc_sign_t;

endpackage : tstc_pkg

// >>> hdl/tstc_trim_if.sv
// Carries one sense input's reading, trim setting and trimmed result.
// Assumes both ends run on the same pclk.
interface tstc_trim_if;
    import tstc_pkg::*;
    logic [TSTC_ADC_W-1:0] reading;
    logic reading_valid;
    logic [TSTC_MAG_W-1:0] magnitude;
    tstc_sign_t sign;
    logic [TSTC_ADC_W-1:0] trimmed;
    logic trimmed_valid;

    modport src (
        output reading,
        output reading_valid,
        output magnitude,
        output sign,
        input trimmed,
        input trimmed_valid
    );

    modport apply (
        input reading,
        input reading_valid,
        input magnitude,
        input sign,
        output trimmed,
        output trimmed_valid
    );
endinterface : tstc_trim_if

// >>> hdl/tstc_trim_apply.sv
// Applies a signed offset trim to one converter reading, saturating.
// Assumes reading and trim come from logic on pclk.
module tstc_trim_apply (
    input wire logic pclk,
    input wire logic presetn,
    tstc_trim_if.apply tif
);
    import tstc_pkg::*;

    logic [TSTC_ADC_W:0] sum;
    logic [TSTC_ADC_W-1:0] result;
    logic [TSTC_ADC_W-1:0] trimmed_reg;
    logic trimmed_valid_reg;

    always_comb begin
        sum = {1'b0, tif.reading} + {4'h0, tif.magnitude};
        result = tif.reading;
        if (tif.sign == TSTC_SIGN_POS) begin
            result = sum[TSTC_ADC_W] ? TSTC_ADC_MAX : sum[TSTC_ADC_W-1:0];
        end else if ({3'h0, tif.magnitude} > tif.reading) begin
            result = TSTC_ADC_MIN;
        end else begin
            result = tif.reading - {3'h0, tif.magnitude};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trimmed_reg <= TSTC_ADC_MIN;
        end else if (tif.reading_valid) begin
            trimmed_reg <= result;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trimmed_valid_reg <= 1'b0;
        end else begin
            trimmed_valid_reg <= tif.reading_valid;
        end
    end

    assign tif.trimmed = trimmed_reg;
    assign tif.trimmed_valid = trimmed_valid_reg;

endmodule : tstc_trim_apply

// >>> hdl/tstc_top.sv
// Trim and excitation settings for two temperature-sense inputs, APB slave.
// Assumes readings arrive from converter logic on pclk with a valid strobe.
//
// Overview of operation
// - Input 1 trim magnitude is upper bit 0 above lower eight bits.
// - Input 2 trim magnitude is upper bit 0 above lower eight bits.
// - Input 1 upper bit 1 picks trim sign: 0 positive, 1 negative.
// - Input 2 upper bit 1 picks trim sign: 1 negative, 0 positive.
// - Input 1 bits 7:6 pick 10, 20, 30 or 40 uA; default 10 uA.
// - Input 2 bits 7:6 pick 10 to 40 uA likewise; default 10 uA.
// - Input 1 bits 5:0 add 156.25 nA per step to its current.
// - Input 2 bits 5:0 add 156.25 nA per step independently.
module tstc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tstc_pkg::TSTC_ADDR_W-1:0] paddr,
    input wire logic [tstc_pkg::TSTC_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [tstc_pkg::TSTC_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [tstc_pkg::TSTC_ADC_W-1:0] temp_sense_input_1_reading,
    input wire logic temp_sense_input_1_reading_valid,
    input wire logic [tstc_pkg::TSTC_ADC_W-1:0] temp_sense_input_2_reading,
    input wire logic temp_sense_input_2_reading_valid,
    output logic [tstc_pkg::TSTC_ADC_W-1:0] temp_sense_input_1_trimmed,
    output logic temp_sense_input_1_trimmed_valid,
    output logic [tstc_pkg::TSTC_ADC_W-1:0] temp_sense_input_2_trimmed,
    output logic temp_sense_input_2_trimmed_valid,
    output logic [1:0] temp_sense_input_1_coarse,
    output logic [5:0] temp_sense_input_1_fine,
    output logic [tstc_pkg::TSTC_CODE_W-1:0] temp_sense_input_1_current,
    output logic [1:0] temp_sense_input_2_coarse,
    output logic [5:0] temp_sense_input_2_fine,
    output logic [tstc_pkg::TSTC_CODE_W-1:0] temp_sense_input_2_current
);
    import tstc_pkg::*;

    // One-hot slot select from a byte address
    function automatic logic [TSTC_NREG-1:0] tstc_decode(
        input logic [TSTC_ADDR_W-1:0] addr
    );
        logic [TSTC_NREG-1:0] sel;
        sel = '0;
        unique case (addr)
            TSTC_ADDR_T1_TRIM_UPPER: sel[TSTC_SLOT_T1_UPPER] = 1'b1;
            TSTC_ADDR_T1_TRIM_LOWER: sel[TSTC_SLOT_T1_LOWER] = 1'b1;
            TSTC_ADDR_T2_TRIM_UPPER: sel[TSTC_SLOT_T2_UPPER] = 1'b1;
            TSTC_ADDR_T2_TRIM_LOWER: sel[TSTC_SLOT_T2_LOWER] = 1'b1;
            TSTC_ADDR_T1_EXC: sel[TSTC_SLOT_T1_EXC] = 1'b1;
            TSTC_ADDR_T2_EXC: sel[TSTC_SLOT_T2_EXC] = 1'b1;
            default: sel = '0;
        endcase
        return sel;
    endfunction : tstc_decode

    // Total excitation in fine steps: (coarse + 1) * 64 + fine
    function automatic logic [TSTC_CODE_W-1:0] tstc_current_code(
        input logic [7:0] exc
    );
        logic [TSTC_CODE_W-1:0] coarse_part;
        coarse_part = {1'b0, exc[TSTC_COARSE_HI:TSTC_COARSE_LO], 6'h00};
        return coarse_part + TSTC_FINE_PER_COARSE
            + {3'h0, exc[TSTC_FINE_HI:TSTC_FINE_LO]};
    endfunction : tstc_current_code

    logic [TSTC_REG_W-1:0] cfg_reg [TSTC_NREG];
    logic [TSTC_DATA_W-1:0] prdata_reg;
    logic [TSTC_DATA_W-1:0] prdata_next;
    logic pready_reg;
    logic pslverr_reg;
    logic [TSTC_NREG-1:0] sel;
    logic access_wait;
    logic access_done;
    logic [1:0] coarse_1_reg;
    logic [5:0] fine_1_reg;
    logic [TSTC_CODE_W-1:0] current_1_reg;
    logic [1:0] coarse_2_reg;
    logic [5:0] fine_2_reg;
    logic [TSTC_CODE_W-1:0] current_2_reg;

    assign sel = tstc_decode(paddr);
    // First access cycle waits; the answer stands in the next one
    assign access_wait = psel && penable && !pready_reg;
    assign access_done = psel && penable && pready_reg;

    // Read data mux
    always_comb begin
        prdata_next = '0;
        for (int k = 0; k < TSTC_NREG; k++) begin
            if (sel[k]) begin
                prdata_next = {24'h000000, cfg_reg[k]};
            end
        end
    end

    // APB ready, one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= access_wait;
        end
    end

    // APB read data and error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= '0;
            pslverr_reg <= 1'b0;
        end else if (access_wait) begin
            prdata_reg <= pwrite ? '0 : prdata_next;
            pslverr_reg <= (sel == '0);
        end else begin
            pslverr_reg <= 1'b0;
        end
    end

    // all eight bits stored, reserved ones included
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < TSTC_NREG; k++) begin
                cfg_reg[k] <= (k >= TSTC_SLOT_T1_EXC) ? TSTC_RST_EXC
                                                      : TSTC_RST_TRIM;
            end
        end else if (access_done && pwrite && pstrb[0]) begin
            for (int k = 0; k < TSTC_NREG; k++) begin
                if (sel[k]) begin
                    cfg_reg[k] <= pwdata[7:0];
                end
            end
        end
    end

    // Trim paths for both sense inputs
    tstc_trim_if trim_if [2] ();

    assign trim_if[0].magnitude = {
        cfg_reg[TSTC_SLOT_T1_UPPER][TSTC_TRIM_MSB_BIT],
        cfg_reg[TSTC_SLOT_T1_LOWER]
    };
    assign trim_if[0].sign =
        tstc_sign_t'(cfg_reg[TSTC_SLOT_T1_UPPER][TSTC_TRIM_SIGN_BIT]);
    assign trim_if[0].reading = temp_sense_input_1_reading;
    assign trim_if[0].reading_valid = temp_sense_input_1_reading_valid;

    assign trim_if[1].magnitude = {
        cfg_reg[TSTC_SLOT_T2_UPPER][TSTC_TRIM_MSB_BIT],
        cfg_reg[TSTC_SLOT_T2_LOWER]
    };
    assign trim_if[1].sign =
        tstc_sign_t'(cfg_reg[TSTC_SLOT_T2_UPPER][TSTC_TRIM_SIGN_BIT]);
    assign trim_if[1].reading = temp_sense_input_2_reading;
    assign trim_if[1].reading_valid = temp_sense_input_2_reading_valid;

    for (genvar g = 0; g < 2; g++) begin : g_trim
        tstc_trim_apply u_apply (
            .pclk(pclk),
            .presetn(presetn),
            .tif(trim_if[g])
        );
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coarse_1_reg <= TSTC_RST_EXC[TSTC_COARSE_HI:TSTC_COARSE_LO];
        end else begin
            coarse_1_reg <=
                cfg_reg[TSTC_SLOT_T1_EXC][TSTC_COARSE_HI:TSTC_COARSE_LO];
        end
    end

    // input 1 fine adjust and total
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fine_1_reg <= TSTC_RST_EXC[TSTC_FINE_HI:TSTC_FINE_LO];
            current_1_reg <= tstc_current_code(TSTC_RST_EXC);
        end else begin
            fine_1_reg <= cfg_reg[TSTC_SLOT_T1_EXC][TSTC_FINE_HI:TSTC_FINE_LO];
            current_1_reg <= tstc_current_code(cfg_reg[TSTC_SLOT_T1_EXC]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coarse_2_reg <= TSTC_RST_EXC[TSTC_COARSE_HI:TSTC_COARSE_LO];
        end else begin
            coarse_2_reg <=
                cfg_reg[TSTC_SLOT_T2_EXC][TSTC_COARSE_HI:TSTC_COARSE_LO];
        end
    end

    // input 2 fine adjust and total
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fine_2_reg <= TSTC_RST_EXC[TSTC_FINE_HI:TSTC_FINE_LO];
            current_2_reg <= tstc_current_code(TSTC_RST_EXC);
        end else begin
            fine_2_reg <= cfg_reg[TSTC_SLOT_T2_EXC][TSTC_FINE_HI:TSTC_FINE_LO];
            current_2_reg <= tstc_current_code(cfg_reg[TSTC_SLOT_T2_EXC]);
        end
    end

    // Outputs
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign temp_sense_input_1_trimmed = trim_if[0].trimmed;
    assign temp_sense_input_1_trimmed_valid = trim_if[0].trimmed_valid;
    assign temp_sense_input_2_trimmed = trim_if[1].trimmed;
    assign temp_sense_input_2_trimmed_valid = trim_if[1].trimmed_valid;
    assign temp_sense_input_1_coarse = coarse_1_reg;
    assign temp_sense_input_1_fine = fine_1_reg;
    assign temp_sense_input_1_current = current_1_reg;
    assign temp_sense_input_2_coarse = coarse_2_reg;
    assign temp_sense_input_2_fine = fine_2_reg;
    assign temp_sense_input_2_current = current_2_reg;

endmodule : tstc_top

// >>> test/tstc_rtd_model.sv
// Behavioural sense resistor: reading follows excitation times resistance.
// Assumes current in 156.25 nA steps, 64 steps giving unit scale.
module tstc_rtd_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic [11:0] res,
    input wire logic [8:0] current,
    output logic [11:0] reading,
    output logic reading_valid
);
    logic [20:0] volts;
    assign volts = (21'(current) * 21'(res)) >> 6;
    // Idle line toggles so stale data never looks valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reading <= 12'h000;
            reading_valid <= 1'b0;
        end else begin
            reading_valid <= go;
            if (go) begin
                reading <= (volts > 21'h000fff) ? 12'hfff : volts[11:0];
            end else begin
                reading <= ~reading;
            end
        end
    end
endmodule : tstc_rtd_model

// >>> test/tstc_top_asserts.sv
// Checker for bus answers, trimmed readings and excitation codes.
// Assumes binding into tstc_top; sees only its ports.
module tstc_top_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tstc_pkg::TSTC_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic temp_sense_input_1_reading_valid,
    input wire logic temp_sense_input_2_reading_valid,
    input wire logic [tstc_pkg::TSTC_ADC_W-1:0] temp_sense_input_1_trimmed,
    input wire logic temp_sense_input_1_trimmed_valid,
    input wire logic [tstc_pkg::TSTC_ADC_W-1:0] temp_sense_input_2_trimmed,
    input wire logic temp_sense_input_2_trimmed_valid,
    input wire logic [1:0] temp_sense_input_1_coarse,
    input wire logic [5:0] temp_sense_input_1_fine,
    input wire logic [tstc_pkg::TSTC_CODE_W-1:0] temp_sense_input_1_current,
    input wire logic [1:0] temp_sense_input_2_coarse,
    input wire logic [5:0] temp_sense_input_2_fine,
    input wire logic [tstc_pkg::TSTC_CODE_W-1:0] temp_sense_input_2_current
);
    import tstc_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_first;
        psel && penable && !pready;
    endsequence
    property p_wait;
        s_setup ##1 s_first |=> pready;
    endproperty
    property p_one;
        pready |=> !pready;
    endproperty
    property p_err;
        pslverr |-> pready && psel && penable;
    endproperty
    property p_errdata;
        pready && pslverr && !pwrite |-> prdata == '0;
    endproperty
    property p_v1;
        temp_sense_input_1_trimmed_valid ==
            $past(temp_sense_input_1_reading_valid);
    endproperty
    property p_v2;
        temp_sense_input_2_trimmed_valid ==
            $past(temp_sense_input_2_reading_valid);
    endproperty
    property p_h1;
        !temp_sense_input_1_reading_valid |=>
            $stable(temp_sense_input_1_trimmed);
    endproperty
    property p_h2;
        !temp_sense_input_2_reading_valid |=>
            $stable(temp_sense_input_2_trimmed);
    endproperty
    property p_c1;
        temp_sense_input_1_current == 9'h040 +
            {1'b0, temp_sense_input_1_coarse, temp_sense_input_1_fine};
    endproperty
    property p_c2;
        temp_sense_input_2_current == 9'h040 +
            {1'b0, temp_sense_input_2_coarse, temp_sense_input_2_fine};
    endproperty
    a_wait: assert property (p_wait) else $error("pready late");
    a_one: assert property (p_one) else $error("pready too long");
    a_err: assert property (p_err) else $error("stray pslverr");
    a_errdata: assert property (p_errdata) else $error("error read data");
    a_v1: assert property (p_v1) else $error("valid 1 timing");
    a_v2: assert property (p_v2) else $error("valid 2 timing");
    a_h1: assert property (p_h1) else $error("trim 1 moved");
    a_h2: assert property (p_h2) else $error("trim 2 moved");
    a_c1: assert property (p_c1) else $error("current 1 code");
    a_c2: assert property (p_c2) else $error("current 2 code");
endmodule : tstc_top_asserts

bind tstc_top tstc_top_asserts u_tstc_top_asserts (.pclk, .presetn, .psel,
    .penable, .pwrite, .prdata, .pready, .pslverr,
    .temp_sense_input_1_reading_valid, .temp_sense_input_2_reading_valid,
    .temp_sense_input_1_trimmed, .temp_sense_input_1_trimmed_valid,
    .temp_sense_input_2_trimmed, .temp_sense_input_2_trimmed_valid,
    .temp_sense_input_1_coarse, .temp_sense_input_1_fine,
    .temp_sense_input_1_current, .temp_sense_input_2_coarse,
    .temp_sense_input_2_fine, .temp_sense_input_2_current);

// >>> test/tstc_top_tb_top.sv
// Self-checking bench: APB master, two sense resistor models.
// Assumes one wait state per transfer as the design answers.
module tstc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tstc_pkg::*;
    typedef struct {int n; logic [7:0] up; logic [7:0] lo;
        logic [11:0] r; logic [11:0] e;} tstc_row_t;
    tstc_row_t rows[8] = '{'{1, 8'h00, 8'h10, 12'd100, 12'd116},
        '{1, 8'h01, 8'h00, 12'd100, 12'd356}, '{1, 8'h03, 8'h00, 12'd100, 0},
        '{1, 8'h02, 8'h05, 12'd100, 12'd95},
        '{1, 8'hfd, 8'hff, 12'd60, 12'd571},
        '{1, 8'h01, 8'hff, 12'd4000, 12'hfff},
        '{2, 8'hfe, 8'h20, 12'd50, 12'd18}, '{2, 8'h01, 8'h01, 12'd10, 267}};
    logic [31:0] al[6] = '{TSTC_ADDR_T1_TRIM_UPPER, TSTC_ADDR_T1_TRIM_LOWER,
        TSTC_ADDR_T2_TRIM_UPPER, TSTC_ADDR_T2_TRIM_LOWER, TSTC_ADDR_T1_EXC,
        TSTC_ADDR_T2_EXC};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, r;
    logic [3:0] pstrb;
    logic go1, go2, r1v, r2v, t1v, t2v, e;
    logic [11:0] res1, res2, rd1, rd2, t1, t2;
    logic [1:0] c1, c2;
    logic [5:0] f1, f2;
    logic [8:0] i1, i2;
    int n_mismatch = 0;
    int n_compared = 0;

    tstc_top u_tstc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .temp_sense_input_1_reading(rd1),
        .temp_sense_input_1_reading_valid(r1v),
        .temp_sense_input_2_reading(rd2),
        .temp_sense_input_2_reading_valid(r2v),
        .temp_sense_input_1_trimmed(t1), .temp_sense_input_1_trimmed_valid(t1v),
        .temp_sense_input_2_trimmed(t2), .temp_sense_input_2_trimmed_valid(t2v),
        .temp_sense_input_1_coarse(c1), .temp_sense_input_1_fine(f1),
        .temp_sense_input_1_current(i1), .temp_sense_input_2_coarse(c2),
        .temp_sense_input_2_fine(f2), .temp_sense_input_2_current(i2));
    tstc_rtd_model u_tstc_rtd_model_1 (.pclk(pclk), .presetn(presetn),
        .go(go1), .res(res1), .current(i1), .reading(rd1), .reading_valid(r1v));
    tstc_rtd_model u_tstc_rtd_model_2 (.pclk(pclk), .presetn(presetn),
        .go(go2), .res(res2), .current(i2), .reading(rd2), .reading_valid(r2v));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic close_out;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    task automatic chk(input bit ok, input string m);
        n_compared++;
        if (!ok) begin
            n_mismatch++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [31:0] a,
        input logic [31:0] d, input logic [3:0] s, output logic [31:0] q,
        output logic er);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            n_mismatch++;
            $display("BAD %0t no pready", $time);
        end
        q = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic er;
        apb(1'b1, a, d, 4'hf, q, er);
    endtask : wr

    task automatic rdc(input logic [31:0] a, input logic [31:0] x,
        input logic xe);
        logic [31:0] q;
        logic er;
        apb(1'b0, a, 32'h0, 4'hf, q, er);
        if (q !== x || er !== xe) begin
            $display("BAD %0t read %h got %h", $time, a, q);
        end
        chk(q === x && er === xe, "read");
    endtask : rdc

    task automatic sense(input int n, input logic [11:0] v,
        input logic [11:0] x);
        int k;
        if (n == 1) begin
            res1 <= v;
            go1 <= 1'b1;
        end else begin
            res2 <= v;
            go2 <= 1'b1;
        end
        @(posedge pclk);
        go1 <= 1'b0;
        go2 <= 1'b0;
        k = 0;
        do begin
            @(posedge pclk);
            #1;
            k++;
        end while (((n == 1) ? t1v : t2v) !== 1'b1 && k < 8);
        chk(((n == 1) ? t1 : t2) === x, "trimmed reading");
    endtask : sense

    initial begin
        #100000;
        n_mismatch++;
        close_out();
    end

    initial begin
        logic [31:0] ua, la;
        presetn = 1'b0;
        {psel, penable, pwrite, go1, go2} = '0;
        {paddr, pwdata, res1, res2} = '0;
        pstrb = 4'hf;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[k]) begin
            ua = rows[k].n == 1 ? TSTC_ADDR_T1_TRIM_UPPER : TSTC_ADDR_T2_TRIM_UPPER;
            la = rows[k].n == 1 ? TSTC_ADDR_T1_TRIM_LOWER : TSTC_ADDR_T2_TRIM_LOWER;
            wr(ua, {24'h0, rows[k].up});
            wr(la, {24'h0, rows[k].lo});
            rdc(ua, {24'h0, rows[k].up}, 1'b0);
            sense(rows[k].n, rows[k].r, rows[k].e);
        end
        for (int c = 0; c < 4; c++) begin
            wr(TSTC_ADDR_T1_EXC, 32'(c * 85));
            wr(TSTC_ADDR_T2_EXC, 32'(c * 43 + 63));
            #1;
            chk(c1 === 2'(c) && f1 === 6'(c * 21) &&
                i1 === 9'((c + 1) * 64 + c * 21), "exc 1");
            chk(c2 === 2'(c) && f2 === 6'(63 - c * 21) &&
                i2 === 9'((c + 1) * 64 + 63 - c * 21), "exc 2");
        end
        apb(1'b1, 32'h0003fa08, 32'h5a, 4'hf, r, e);
        chk(e === 1'b1, "unmapped write");
        rdc(32'h0003fa08, 32'h0, 1'b1);
        apb(1'b1, TSTC_ADDR_T1_EXC, 32'h0, 4'h0, r, e);
        rdc(TSTC_ADDR_T1_EXC, 32'hff, 1'b0);
        wr(TSTC_ADDR_T1_TRIM_UPPER, 32'h0);
        wr(TSTC_ADDR_T1_TRIM_LOWER, 32'h0);
        sense(1, 12'd64, 12'd319);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        chk(i1 === 9'h040 && i2 === 9'h040 && c1 === 2'b00, "reset exc");
        foreach (al[j]) begin
            rdc(al[j], 32'h0, 1'b0);
        end
        close_out();
    end
endmodule : tstc_top_tb_top
